// ==== design/slfc_pkg.sv ====
// Constants shared by the serial LED frame capture logic
package slfc_pkg;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int unsigned NUM_PORTS       = 8;
	localparam int unsigned PORT_W          = 3;
	localparam int unsigned BITPOS_W        = 7;
	localparam logic [6:0]  BITPOS_LOAD     = 7'h01;
	localparam logic [6:0]  BITPOS_ONE      = 7'h01;
	localparam logic [6:0]  BITPOS_MAX      = 7'h7F;
	// Counter values seen while frame bits 9 and 72 are on the line
	localparam logic [6:0]  STATUS_FIRST_POS = 7'h08;
	localparam logic [6:0]  STATUS_LAST_POS  = 7'h47;
	// Counter value while bit 73 is on the line: all status is in
	localparam logic [6:0]  FRAME_DONE_POS   = 7'h48;

	// ****************************************
	// Captured status kinds, 0..5 map to codes 0,1,2,4,5,6
	// ****************************************
	localparam int unsigned NUM_CAPT  = 6;
	localparam int unsigned CAPT_TX   = 0;
	localparam int unsigned CAPT_RX   = 1;
	localparam int unsigned CAPT_COL  = 2;
	localparam int unsigned CAPT_UNK  = 3;
	localparam int unsigned CAPT_SNF  = 4;
	localparam int unsigned CAPT_FDX  = 5;
	localparam int unsigned CAPT_SKIP = 3;

	// ****************************************
	// Activity source select codes
	// ****************************************
	localparam logic [1:0] ACT_SEL_EITHER = 2'h0;
	localparam logic [1:0] ACT_SEL_TX     = 2'h1;
	localparam logic [1:0] ACT_SEL_RX     = 2'h2;
	localparam logic [1:0] ACT_SEL_COL    = 2'h3;

	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam int unsigned ADDR_W         = 5;
	localparam logic [4:0]  ADDR_CTRL      = 5'h00;
	localparam logic [4:0]  ADDR_LINK_STAT = 5'h04;
	localparam logic [4:0]  ADDR_CFG_STAT  = 5'h08;
	localparam logic [4:0]  ADDR_FRAMES    = 5'h0C;
	localparam int unsigned CTRL_SEL_LSB   = 0;
	localparam int unsigned CTRL_TEST_BIT  = 2;
	localparam int unsigned CTRL_CLEAR_BIT = 3;
	localparam logic [1:0]  CTRL_SEL_RST   = 2'h0;
	localparam logic        CTRL_TEST_RST  = 1'h0;
	localparam logic        CTRL_CLEAR_RST = 1'h0;
	localparam int unsigned BYTE_LANE_CTRL = 0;

endpackage

// ==== design/slfc_sync.sv ====
// Two-stage level synchroniser into the destination clock
`timescale 1ns/100ps
module slfc_sync #(
	parameter int unsigned WIDTH  = 1,
	parameter int unsigned STAGES = 2
) (
	input  wire logic             clk_in,
	input  wire logic             arst_n_in,
	input  wire logic [WIDTH-1:0] level_in,
	output logic      [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] stage_q [STAGES];

	if (STAGES < 2)
	begin : g_bad_stages
		$error("slfc_sync needs at least two stages");
	end

	// Only the next stage reads each stage
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			for (int i = 0; i < STAGES; i++)
				stage_q[i] <= '0;
		end
		else
		begin
			stage_q[0] <= level_in;
			for (int i = 1; i < STAGES; i++)
				stage_q[i] <= stage_q[i-1];
		end
	end

	assign level_out = stage_q[STAGES-1];

endmodule

// ==== design/slfc_capture.sv ====
// Serial LED status frame capture with Avalon-MM control registers
//
// Contract
// - Reserved positions and bits 73 to 128 never reach any LED.
// - Serial data is sampled on the falling edge of the link clock.
// - 7-bit position counter loads 1 on strobe, else counts each clock.
// - Position counter stops at 127 until the next strobe.
// - Counter decode picks kind and port, enabling one capture flop.
// - Strobe walks an 8-bit one-hot shifter enabling link captures.
// - At most one shifter stage is high; no capture past bit 72.
// - Each port drives link, activity, receive and collision LEDs.
// - Activity select: 00 rx or tx, 01 tx, 10 rx, 11 collision.
// - Test select 0 takes switch clock, strobe, data; 1 the substitutes.
// - While clear is set every LED output is off.
// - All LED outputs are active low; true status lights the LED.
`timescale 1ns/100ps
module slfc_capture
	import slfc_pkg::*;
#(
	parameter int unsigned FRAME_CNT_W = 16
) (
	input  wire logic                 clk_sys_in,
	input  wire logic                 arst_n_in,
	input  wire logic                 status_serial_clock_in,
	input  wire logic                 frame_strobe_in,
	input  wire logic                 status_serial_data_n_in,
	input  wire logic                 substitute_clock_in,
	input  wire logic                 substitute_strobe_in,
	input  wire logic                 substitute_data_n_in,
	input  wire logic [ADDR_W-1:0]    avs_address_in,
	input  wire logic                 avs_read_in,
	input  wire logic                 avs_write_in,
	input  wire logic [31:0]          avs_writedata_in,
	input  wire logic [3:0]           avs_byteenable_in,
	output logic      [31:0]          avs_readdata_out,
	output logic                      avs_waitrequest_out,
	output logic      [NUM_PORTS-1:0] led_link_n_out,
	output logic      [NUM_PORTS-1:0] led_activity_n_out,
	output logic      [NUM_PORTS-1:0] led_receive_n_out,
	output logic      [NUM_PORTS-1:0] led_collision_n_out
);

	if (FRAME_CNT_W < 1 || FRAME_CNT_W > 32)
	begin : g_bad_cnt
		$error("FRAME_CNT_W must lie in 1..32");
	end

	// ****************************************
	// Declarations
	// ****************************************
	logic [1:0]             ctrl_sel_q;
	logic                   ctrl_test_q;
	logic                   ctrl_clear_q;
	logic                   link_clk;
	logic                   internal_frame_strobe;
	logic                   data_n_mux;
	logic                   data_true;
	logic                   lrst_meta_q;
	logic                   lrst_n_q;
	logic [BITPOS_W-1:0]    bitpos_q;
	logic [BITPOS_W-1:0]    bitpos_d;
	logic [BITPOS_W-1:0]    status_off;
	logic [PORT_W-1:0]      status_port;
	logic [2:0]             status_kind;
	logic                   in_status;
	logic [NUM_PORTS-1:0]   shift_q;
	logic [NUM_PORTS-1:0]   link_en;
	logic [NUM_PORTS-1:0]   link_q;
	logic [NUM_PORTS-1:0]   cap_en [NUM_CAPT];
	logic [NUM_PORTS-1:0]   stat_q [NUM_CAPT];
	logic                   done_tgl_q;
	logic                   done_sync;
	logic                   done_prev_q;
	logic                   frame_pulse;
	logic [NUM_PORTS-1:0]   link_s_q;
	logic [NUM_PORTS-1:0]   stat_s_q [NUM_CAPT];
	logic [FRAME_CNT_W-1:0] frame_cnt_q;
	logic [NUM_PORTS-1:0]   act_true;
	logic                   bus_req;
	logic                   bus_accept;
	logic                   ctrl_wr;
	logic [31:0]            rd_mux;
	logic                   wait_q;
	logic [31:0]            rdata_q;

	// ****************************************
	// Source selection
	// ****************************************
	// The clock mux is steered from the system domain; switching test
	// mode may glitch the link clock, so frames around a switch are lost
	assign link_clk = ctrl_test_q ? substitute_clock_in
		: status_serial_clock_in;
	assign internal_frame_strobe = ctrl_test_q ? substitute_strobe_in
		: frame_strobe_in;
	assign data_n_mux = ctrl_test_q ? substitute_data_n_in
		: status_serial_data_n_in;
	assign data_true = ~data_n_mux;

	// ****************************************
	// Link domain reset release
	// ****************************************
	always_ff @(negedge link_clk or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			lrst_meta_q <= 1'b0;
			lrst_n_q    <= 1'b0;
		end
		else
		begin
			lrst_meta_q <= 1'b1;
			lrst_n_q    <= lrst_meta_q;
		end
	end

	// ****************************************
	// Bit position counter
	// ****************************************
	// Counter holds the number of the bit just sampled
	assign bitpos_d = internal_frame_strobe ? BITPOS_LOAD
		: (bitpos_q == BITPOS_MAX) ? bitpos_q
		: bitpos_q + BITPOS_ONE;

	// Reset to the halt value so nothing is captured before a strobe
	always_ff @(negedge link_clk or negedge lrst_n_q)
	begin
		if (!lrst_n_q)
			bitpos_q <= BITPOS_MAX;
		else
			bitpos_q <= bitpos_d;
	end

	// ****************************************
	// Status decode and capture
	// ****************************************
	// Only counter values 8..71 open a capture, so bits past 72 are dropped
	assign in_status = !internal_frame_strobe
		&& bitpos_q >= STATUS_FIRST_POS
		&& bitpos_q <= STATUS_LAST_POS;
	assign status_off  = bitpos_q - STATUS_FIRST_POS;
	assign status_port = status_off[5:3];
	assign status_kind = status_off[2:0];

	for (genvar c = 0; c < NUM_CAPT; c++)
	begin : g_capt
		// Kind codes 3 and 7 are reserved and have no flop
		localparam logic [2:0] KIND = 3'(c + c / CAPT_SKIP);
		for (genvar p = 0; p < NUM_PORTS; p++)
		begin : g_port
			assign cap_en[c][p] = in_status
				&& status_port == PORT_W'(p)
				&& status_kind == KIND;
		end

		always_ff @(negedge link_clk or negedge lrst_n_q)
		begin
			if (!lrst_n_q)
				stat_q[c] <= '0;
			else
				for (int p = 0; p < NUM_PORTS; p++)
					if (cap_en[c][p])
						stat_q[c][p] <= data_true;
		end
	end

	// ****************************************
	// Link state capture
	// ****************************************
	assign link_en = {shift_q[NUM_PORTS-2:0], internal_frame_strobe};

	always_ff @(negedge link_clk or negedge lrst_n_q)
	begin
		if (!lrst_n_q)
			shift_q <= '0;
		else
			shift_q <= {shift_q[NUM_PORTS-2:0], internal_frame_strobe};
	end

	always_ff @(negedge link_clk or negedge lrst_n_q)
	begin
		if (!lrst_n_q)
			link_q <= '0;
		else
			for (int p = 0; p < NUM_PORTS; p++)
				if (link_en[p])
					link_q[p] <= data_true;
	end

	// ****************************************
	// Frame done event into the system domain
	// ****************************************
	// Captures are idle from bit 73 to the next bit 1, so the words are
	// stable for 56 link clock periods after this toggle
	always_ff @(negedge link_clk or negedge lrst_n_q)
	begin
		if (!lrst_n_q)
			done_tgl_q <= 1'b0;
		else if (!internal_frame_strobe && bitpos_q == FRAME_DONE_POS)
			done_tgl_q <= ~done_tgl_q;
	end

	slfc_sync #(
		.WIDTH  (1),
		.STAGES (2)
	) u_done_sync (
		.clk_in    (clk_sys_in),
		.arst_n_in (arst_n_in),
		.level_in  (done_tgl_q),
		.level_out (done_sync)
	);

	assign frame_pulse = done_sync ^ done_prev_q;

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			done_prev_q <= 1'b0;
			link_s_q    <= '0;
			frame_cnt_q <= '0;
			for (int c = 0; c < NUM_CAPT; c++)
				stat_s_q[c] <= '0;
		end
		else
		begin
			done_prev_q <= done_sync;
			if (frame_pulse)
			begin
				link_s_q    <= link_q;
				frame_cnt_q <= frame_cnt_q + FRAME_CNT_W'(1);
				for (int c = 0; c < NUM_CAPT; c++)
					stat_s_q[c] <= stat_q[c];
			end
		end
	end

	// ****************************************
	// LED drivers
	// ****************************************
	assign act_true =
		(ctrl_sel_q == ACT_SEL_EITHER) ?
			(stat_s_q[CAPT_TX] | stat_s_q[CAPT_RX]) :
		(ctrl_sel_q == ACT_SEL_TX) ? stat_s_q[CAPT_TX] :
		(ctrl_sel_q == ACT_SEL_RX) ? stat_s_q[CAPT_RX] :
		stat_s_q[CAPT_COL];

	// Off is all ones; clear overrides any captured status
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			led_link_n_out      <= '1;
			led_activity_n_out  <= '1;
			led_receive_n_out   <= '1;
			led_collision_n_out <= '1;
		end
		else if (ctrl_clear_q)
		begin
			led_link_n_out      <= '1;
			led_activity_n_out  <= '1;
			led_receive_n_out   <= '1;
			led_collision_n_out <= '1;
		end
		else
		begin
			led_link_n_out      <= ~link_s_q;
			led_activity_n_out  <= ~act_true;
			led_receive_n_out   <= ~stat_s_q[CAPT_RX];
			led_collision_n_out <= ~stat_s_q[CAPT_COL];
		end
	end

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	// One wait cycle per access: read data loads on the same edge that drops waitrequest
	assign bus_req    = avs_read_in | avs_write_in;
	assign bus_accept = bus_req && !wait_q;
	assign ctrl_wr    = bus_accept && avs_write_in
		&& avs_address_in == ADDR_CTRL
		&& avs_byteenable_in[BYTE_LANE_CTRL];

	assign rd_mux =
		(avs_address_in == ADDR_CTRL) ?
			{28'h0000000, ctrl_clear_q, ctrl_test_q, ctrl_sel_q} :
		(avs_address_in == ADDR_LINK_STAT) ?
			{stat_s_q[CAPT_COL], stat_s_q[CAPT_RX],
			 stat_s_q[CAPT_TX], link_s_q} :
		(avs_address_in == ADDR_CFG_STAT) ?
			{8'h00, stat_s_q[CAPT_FDX], stat_s_q[CAPT_SNF],
			 stat_s_q[CAPT_UNK]} :
		(avs_address_in == ADDR_FRAMES) ? 32'(frame_cnt_q) :
		32'h00000000;

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			wait_q <= !(bus_req && wait_q);
			if (bus_req && wait_q)
				rdata_q <= rd_mux;
		end
	end

	assign avs_waitrequest_out = wait_q;
	assign avs_readdata_out    = rdata_q;

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ctrl_sel_q   <= CTRL_SEL_RST;
			ctrl_test_q  <= CTRL_TEST_RST;
			ctrl_clear_q <= CTRL_CLEAR_RST;
		end
		else if (ctrl_wr)
		begin
			ctrl_sel_q   <= avs_writedata_in[CTRL_SEL_LSB +: 2];
			ctrl_test_q  <= avs_writedata_in[CTRL_TEST_BIT];
			ctrl_clear_q <= avs_writedata_in[CTRL_CLEAR_BIT];
		end
	end

	// ****************************************
	// Link domain checks
	// ****************************************
	cnt_load_a: assert property (
		@(negedge link_clk) disable iff (!lrst_n_q)
		internal_frame_strobe |=> bitpos_q == BITPOS_LOAD)
		else $error("position counter not loaded by strobe");

	cnt_count_a: assert property (
		@(negedge link_clk) disable iff (!lrst_n_q)
		(!internal_frame_strobe && bitpos_q != BITPOS_MAX)
		|=> bitpos_q == $past(bitpos_q) + BITPOS_ONE)
		else $error("position counter did not advance");

	cnt_halt_a: assert property (
		@(negedge link_clk) disable iff (!lrst_n_q)
		(!internal_frame_strobe && bitpos_q == BITPOS_MAX)
		|=> bitpos_q == BITPOS_MAX)
		else $error("position counter left its halt value");

	shift_onehot_a: assert property (
		@(negedge link_clk) disable iff (!lrst_n_q)
		$onehot0(shift_q))
		else $error("more than one strobe stage high");

	late_capture_a: assert property (
		@(negedge link_clk) disable iff (!lrst_n_q)
		(bitpos_q > STATUS_LAST_POS) |-> !(|cap_en[CAPT_TX]
			|| |cap_en[CAPT_RX] || |cap_en[CAPT_COL]))
		else $error("capture enabled on a reserved position");

	tx_capture_a: assert property (
		@(negedge link_clk) disable iff (!lrst_n_q)
		cap_en[CAPT_TX][1] |=> stat_q[CAPT_TX][1] == $past(data_true))
		else $error("port 1 transmit bit not captured");

	tx_hold_a: assert property (
		@(negedge link_clk) disable iff (!lrst_n_q)
		!(|cap_en[CAPT_TX]) |=> $stable(stat_q[CAPT_TX]))
		else $error("transmit status changed without enable");

	sequence frame_start_s;
		internal_frame_strobe ##1 !internal_frame_strobe;
	endsequence

	link_walk_a: assert property (
		@(negedge link_clk) disable iff (!lrst_n_q)
		frame_start_s |-> ##1 link_q[1] == $past(data_true))
		else $error("port 1 link state not captured at bit 2");

	// ****************************************
	// System domain checks
	// ****************************************
	clear_off_a: assert property (
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		ctrl_clear_q |=> (&led_link_n_out && &led_activity_n_out
			&& &led_receive_n_out && &led_collision_n_out))
		else $error("LED lit while clear set");

	act_tx_a: assert property (
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(!ctrl_clear_q && ctrl_sel_q == ACT_SEL_TX)
		|=> led_activity_n_out == ~$past(stat_s_q[CAPT_TX]))
		else $error("activity LED not showing transmit");

	sequence ctrl_write_s;
		ctrl_wr;
	endsequence

	ctrl_write_a: assert property (
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		ctrl_write_s |=>
			ctrl_test_q == $past(avs_writedata_in[CTRL_TEST_BIT]))
		else $error("test select not written");

endmodule

// ==== dv/slfc_sender.sv ====
// Behavioural switch controller sending the serial LED status frame
`timescale 1ns/100ps
module slfc_sender #(
	parameter int PHASE_NS = 7
) (
	input  wire logic [127:0] frame_true_in,
	output logic              clock_out,
	output logic              strobe_out,
	output logic              data_n_out
);
	int unsigned pos = 0;
	logic        strobe_q = 1'h0;
	logic        data_n_q = 1'h1;

	// One driver per output: the frame process owns strobe and data
	assign strobe_out = strobe_q;
	assign data_n_out = data_n_q;

	// Free running from time zero, never stopped between frames
	initial
	begin
		clock_out = 1'h0;
		#(PHASE_NS);
		forever
		begin
			#32 clock_out = ~clock_out;
		end
	end

	// Index k-1 of the frame vector is frame bit k, 1 means status true
	always @(posedge clock_out)
	begin
		strobe_q <= (pos == 0);
		data_n_q <= ~frame_true_in[pos];
		pos <= (pos + 1) % 128;
	end
endmodule

// ==== dv/tb_serial_led_frame_capture.sv ====
// Self-checking bench for the serial LED frame capture block
`timescale 1ns/100ps
module tb_serial_led_frame_capture;
	import slfc_pkg::*;
	logic              clk_sys_in = 1'h0;
	logic              arst_n_in = 1'h1;
	logic [ADDR_W-1:0] avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_writedata;
	logic [3:0]        avs_byteenable;
	logic [127:0]      sw_frame;
	logic [127:0]      sub_frame;
	logic [31:0]       rd;
	logic [31:0]       frames0;
	wire  [31:0]       avs_readdata;
	wire               avs_waitrequest;
	wire  [7:0]        led_link_n;
	wire  [7:0]        led_act_n;
	wire  [7:0]        led_rx_n;
	wire  [7:0]        led_col_n;
	wire               sw_clk;
	wire               sw_stb;
	wire               sw_data_n;
	wire               sub_clk;
	wire               sub_stb;
	wire               sub_data_n;
	int                n_mismatch = 0;
	int                n_compared = 0;
	int                seed = 32'h6EE2;

	always #2 clk_sys_in = ~clk_sys_in;

	slfc_sender #(.PHASE_NS(7)) sw_side (
		.frame_true_in(sw_frame), .clock_out(sw_clk),
		.strobe_out(sw_stb), .data_n_out(sw_data_n));
	// Processor output port plays the same frame format
	slfc_sender #(.PHASE_NS(19)) sub_side (
		.frame_true_in(sub_frame), .clock_out(sub_clk),
		.strobe_out(sub_stb), .data_n_out(sub_data_n));

	slfc_capture dut (
		.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.status_serial_clock_in(sw_clk), .frame_strobe_in(sw_stb),
		.status_serial_data_n_in(sw_data_n),
		.substitute_clock_in(sub_clk), .substitute_strobe_in(sub_stb),
		.substitute_data_n_in(sub_data_n),
		.avs_address_in(avs_address), .avs_read_in(avs_read),
		.avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
		.avs_byteenable_in(avs_byteenable),
		.avs_readdata_out(avs_readdata),
		.avs_waitrequest_out(avs_waitrequest),
		.led_link_n_out(led_link_n), .led_activity_n_out(led_act_n),
		.led_receive_n_out(led_rx_n), .led_collision_n_out(led_col_n));

	// ****************************************
	// Reference model and comparisons
	// ****************************************
	function automatic logic [7:0] field(input logic [127:0] f,
		input int base, input int step);
		logic [7:0] r;
		for (int p = 0; p < 8; p++)
			r[p] = f[base + step * p];
		return r;
	endfunction

	task automatic finish_test();
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk_reg(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_led(input logic [31:0] exp);
		n_compared++;
		if ({led_link_n, led_act_n, led_rx_n, led_col_n} !== exp)
		begin
			n_mismatch++;
			$display("BAD leds expected %h seen %h", exp,
				{led_link_n, led_act_n, led_rx_n, led_col_n});
		end
	endtask

	// Link from bits 1..8, tx rx col from 8n+9 on; reserved bits skipped
	task automatic check_leds(input logic [127:0] f, input int s,
		input logic clr);
		logic [7:0] tx;
		logic [7:0] rx;
		logic [7:0] act;
		tx = field(f, 8, 8);
		rx = field(f, 9, 8);
		case (s)
			0: act = tx | rx;
			1: act = tx;
			2: act = rx;
			default: act = field(f, 10, 8);
		endcase
		if (clr)
			chk_led(32'hFFFFFFFF);
		else
			chk_led(~{field(f, 0, 1), act, rx, field(f, 10, 8)});
	endtask

	task automatic check_stat(input logic [127:0] f);
		logic [31:0] d;
		bus_read(ADDR_LINK_STAT, d);
		chk_reg("link_stat", {field(f, 10, 8), field(f, 9, 8),
			field(f, 8, 8), field(f, 0, 1)}, d);
		bus_read(ADDR_CFG_STAT, d);
		chk_reg("cfg_stat", {8'h00, field(f, 14, 8), field(f, 13, 8),
			field(f, 12, 8)}, d);
	endtask

	// ****************************************
	// Avalon-MM master
	// ****************************************
	task automatic bus_wait();
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys_in);
			n++;
		end
		while (avs_waitrequest !== 1'h0 && n < 20);
		if (avs_waitrequest !== 1'h0)
		begin
			n_mismatch++;
			finish_test();
		end
	endtask

	task automatic bus_read(input logic [ADDR_W-1:0] a,
		output logic [31:0] d);
		@(posedge clk_sys_in);
		avs_address <= a;
		avs_read <= 1'h1;
		bus_wait();
		d = avs_readdata;
		avs_read <= 1'h0;
	endtask

	task automatic bus_write(input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_sys_in);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= 1'h1;
		bus_wait();
		avs_write <= 1'h0;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		// Late in time zero, so every reset flop sees a clean falling edge
		arst_n_in <= 1'h0;
		avs_address = 5'h00;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		sw_frame = 128'h0;
		sub_frame = 128'h0;
		// Link side resets at once; it releases on its own clock later
		repeat (10) @(posedge clk_sys_in);
		chk_led(32'hFFFFFFFF);
		arst_n_in <= 1'h1;
		bus_read(ADDR_CTRL, rd);
		chk_reg("ctrl_reset", 32'h0, rd);
		// Each frame also steps through one activity selection
		for (int i = 0; i < 6; i++)
		begin
			bus_write(ADDR_CTRL, i % 4, 4'hF);
			sw_frame <= (i == 0) ? '1 : (i == 1) ? '0 : {$random(seed),
				$random(seed), $random(seed), $random(seed)};
			repeat (4400) @(posedge clk_sys_in);
			check_leds(sw_frame, i % 4, 1'h0);
			check_stat(sw_frame);
		end
		bus_write(ADDR_CTRL, 32'h9, 4'hF);
		repeat (100) @(posedge clk_sys_in);
		check_leds(sw_frame, 1, 1'h1);
		repeat (4400) @(posedge clk_sys_in);
		check_leds(sw_frame, 1, 1'h1);
		bus_write(ADDR_CTRL, 32'h1, 4'hF);
		repeat (100) @(posedge clk_sys_in);
		check_leds(sw_frame, 1, 1'h0);
		bus_write(ADDR_LINK_STAT, 32'hFFFFFFFF, 4'hF);
		bus_write(ADDR_CTRL, 32'h8, 4'h0);
		bus_read(ADDR_CTRL, rd);
		chk_reg("ctrl_kept", 32'h1, rd);
		check_stat(sw_frame);
		bus_read(5'h10, rd);
		chk_reg("unmapped", 32'h0, rd);
		bus_read(ADDR_FRAMES, frames0);
		// Read data loads exactly 8192 cycles apart, four whole frames,
		// so the count cannot depend on where the frame edge falls
		repeat (8189) @(posedge clk_sys_in);
		bus_read(ADDR_FRAMES, rd);
		chk_reg("frames", (frames0 + 32'h4) & 32'h0000FFFF, rd);
		sub_frame <= {$random(seed), $random(seed), $random(seed),
			$random(seed)};
		bus_write(ADDR_CTRL, 32'h4, 4'hF);
		repeat (4400) @(posedge clk_sys_in);
		check_leds(sub_frame, 0, 1'h0);
		check_stat(sub_frame);
		bus_write(ADDR_CTRL, 32'h0, 4'hF);
		repeat (4400) @(posedge clk_sys_in);
		check_leds(sw_frame, 0, 1'h0);
		finish_test();
	end
endmodule
